// File: sru_consts.vh
// Behaviour
// - enable takes over serial input pin
// - synchronous mode samples on transfer clock
// - start bit begins frame, shift to stop
// - only first stop bit checked
// - completed frame moves into receive buffer
// - unused upper data bits read zero
// - ninth bit shown in control register
// - data read advances fifo and flags
// - complete flag set while buffer nonempty
// - disable stops reception, releases pin
// - disable empties the fifo
// - irq follows complete flag when enabled
// - error flags stored with each character
// - error flag writes ignored, no irq
// - frame error equals inverted stop bit
// - overrun when fifo full, shifter full, start
// - overrun clears on successful transfer
// - parity check when upper mode bit set
// - parity error zero when checking disabled
// - oversample 16x, or 8x double speed
// - start bit majority vote, reject noise
// - bits decided by three-sample majority in async mode, by one sample on the transfer clock edge in sync mode
`ifndef SRU_CONSTS_VH
`define SRU_CONSTS_VH
`define SRU_ADDR_DATA     2'h0
`define SRU_ADDR_STATUS_A 2'h1
`define SRU_ADDR_CTRL_B   2'h2
`define SRU_ADDR_CTRL_C   2'h3
`define SRU_A_COMPLETE    7
`define SRU_A_FRAME_ERR   4
`define SRU_A_OVERRUN     3
`define SRU_A_PARITY_ERR  2
`define SRU_A_DOUBLE      1
`define SRU_B_IRQ_EN      7
`define SRU_B_RX_EN       4
`define SRU_B_SIZE2       2
`define SRU_B_NINTH       1
`define SRU_C_SYNC        6
`define SRU_C_PAR_HI      5
`define SRU_C_PAR_LO      4
`define SRU_C_STOP_SEL    3
`define SRU_C_SIZE_HI     2
`define SRU_C_SIZE_LO     1
`define SRU_SIZE_NINE     3'h7
`define SRU_OVS_NORMAL    5'h10
`define SRU_OVS_DOUBLE    5'h08
`define SRU_FIFO_DEPTH    2
`define SRU_BAUD_RST      12'h000
`define SRU_SIZE_LO_RST   2'h3
`endif

// File: sru_line_model.sv
`default_nettype none
module sru_line_model (
	output logic line,
	output logic xck
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		line = 1'b1;
		xck  = 1'b0;
	end
	// bits go out lsb first, each held one whole bit time
	task automatic send(input logic [12:0] f, input int n, input int bt, input bit sync);
		for (int i = 0; i < n; i++) begin
			line = f[i];
			#(bt / 2) xck = sync;
			#(bt / 2) xck = 1'b0;
		end
		line = 1'b1;
	endtask
	task automatic glitch(input int t);
		line = 1'b0;
		#t line = 1'b1;
	endtask
endmodule
`default_nettype wire

// File: sru_receiver.v
`include "sru_consts.vh"
`default_nettype none
module sru_receiver (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire [1:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire [11:0] baud_div,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        serial_in_pin,
	input  wire        transfer_clock_pin,
	output wire        serial_in_override,
	output wire        rx_complete_irq
);
	localparam ST_IDLE  = 3'b001;
	localparam ST_START = 3'b010;
	localparam ST_BITS  = 3'b100;

	// control registers
	reg        receiver_enable_r;
	reg        rx_complete_irq_enable_r;
	reg        size2_r;
	reg        double_speed_select_r;
	reg        sync_mode_r;
	reg  [1:0] parity_mode_field_r;
	reg        stop_bit_select_r;
	reg  [1:0] size_lo_r;
	wire [2:0] char_size_field = {size2_r, size_lo_r};

	// three-stage input synchronisers
	reg  [2:0] rxd_sync_r;
	reg  [2:0] xck_sync_r;
	reg        rxd_clean_r;
	reg        xck_clean_r;
	reg        xck_prev_r;
	// serial line
	always @(posedge sys_clk) begin
		if (rst) begin
			rxd_sync_r  <= 3'h7;
			rxd_clean_r <= 1'b1;
		end else begin
			rxd_sync_r <= {rxd_sync_r[1:0], serial_in_pin};
			if (rxd_sync_r[1] == rxd_sync_r[2])
				rxd_clean_r <= rxd_sync_r[2];
		end
	end

	// transfer clock
	always @(posedge sys_clk) begin
		if (rst) begin
			xck_sync_r  <= 3'h0;
			xck_clean_r <= 1'b0;
			xck_prev_r  <= 1'b0;
		end else begin
			xck_sync_r <= {xck_sync_r[1:0], transfer_clock_pin};
			if (xck_sync_r[1] == xck_sync_r[2])
				xck_clean_r <= xck_sync_r[2];
			xck_prev_r <= xck_clean_r;
		end
	end

	// rising edge of the filtered transfer clock
	wire xck_rise = xck_clean_r & ~xck_prev_r;
	// input gated while disabled: line looks idle
	wire rxd = rxd_clean_r | ~receiver_enable_r;

	// oversample tick from internal baud divider
	reg  [11:0] baud_cnt_r;
	wire        os_tick = (baud_cnt_r == 12'h000);
	wire        baud_reload = rst || !receiver_enable_r || os_tick;
	wire [11:0] baud_load   = rst ? `SRU_BAUD_RST : baud_div;
	always @(posedge sys_clk) begin
		if (baud_reload)
			baud_cnt_r <= baud_load;
		else
			baud_cnt_r <= baud_cnt_r - 12'h001;
	end

	wire [4:0] ovs = double_speed_select_r ? `SRU_OVS_DOUBLE : `SRU_OVS_NORMAL;
	wire [4:0] mid = {1'b0, ovs[4:1]};   // 8 or 4: middle voted sample

	// frame length: data bits + optional parity + first stop
	wire [3:0] data_bits = (char_size_field == `SRU_SIZE_NINE) ? 4'h9 : {2'b00, size_lo_r} + 4'h5;
	wire       par_on    = parity_mode_field_r[1];
	wire [3:0] last_bit  = data_bits + {3'b000, par_on}; // index of stop bit

	reg  [2:0] state_r;
	reg  [4:0] samp_r;
	reg  [1:0] votes_r;
	reg  [3:0] bit_idx_r;
	reg  [8:0] shift_r;
	reg        par_bit_r;
	reg        hold_full_r;
	reg  [8:0] hold_data_r;
	reg        hold_fe_r;
	reg        hold_pe_r;
	reg        ovr_pend_r;

	// fifo storage: data[8:0], frame, overrun, parity
	reg  [11:0] fifo_mem [0:`SRU_FIFO_DEPTH-1];
	reg         rd_ptr_r;
	reg         wr_ptr_r;
	reg  [1:0]  count_r;
	wire        fifo_full  = (count_r == 2'd2);
	wire        rx_complete_flag = receiver_enable_r && (count_r != 2'd0);
	wire        data_read  = reg_rd && (reg_addr == `SRU_ADDR_DATA);
	wire        pop        = data_read && rx_complete_flag;
	wire        push       = hold_full_r && (!fifo_full || pop);

	wire sample_evt = sync_mode_r ? xck_rise : os_tick;
	wire vote_bit   = (votes_r[1] | (votes_r[0] & rxd)); // 2 of 3 high
	reg  [1:0] vote_cnt;
	always @* begin
		vote_cnt = votes_r + {1'b0, rxd};
		if (votes_r == 2'd2)
			vote_cnt = 2'd2;
	end

	wire start_seen = (state_r == ST_IDLE) && !rxd && receiver_enable_r;

	// expected parity over received data
	wire [8:0] data_mask = (9'h1ff >> (4'h9 - data_bits));
	wire       par_calc  = ^(shift_r & data_mask) ^ parity_mode_field_r[0];
	wire       bit_val   = sync_mode_r ? rxd : vote_bit;
	// one bit decided; the hold stage takes the frame at the first stop bit
	wire       bit_done  = (state_r == ST_BITS) && sample_evt && (sync_mode_r || samp_r == mid + 5'h01);
	wire       hold_load = bit_done && (bit_idx_r == last_bit) && (!hold_full_r || push);

	always @(posedge sys_clk) begin
		if (rst || !receiver_enable_r) begin
			state_r   <= ST_IDLE;
			samp_r    <= 5'h00;
			votes_r   <= 2'h0;
			bit_idx_r <= 4'h0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (start_seen) begin
					state_r   <= ST_START;
					samp_r    <= 5'h00;
					votes_r   <= 2'h0;
					bit_idx_r <= 4'h0;
				end
			end
			ST_START: if (sample_evt) begin
				if (sync_mode_r) begin
					// first transfer clock edge must still see the start bit
					state_r <= rxd ? ST_IDLE : ST_BITS;
				end else begin
					samp_r <= samp_r + 5'h01;
					if (samp_r >= mid - 5'h01 && samp_r <= mid + 5'h01)
						votes_r <= vote_cnt;
					if (samp_r == mid + 5'h01) begin
						if (vote_bit)
							state_r <= ST_IDLE;
						else begin
							state_r <= ST_BITS;
							votes_r <= 2'h0;
						end
					end
					if (samp_r == ovs - 5'h01)
						samp_r <= 5'h00;
				end
			end
			ST_BITS: if (sample_evt) begin
				if (sync_mode_r)
					samp_r <= 5'h00;
				else begin
					samp_r <= (samp_r == ovs - 5'h01) ? 5'h00 : samp_r + 5'h01;
					if (samp_r >= mid - 5'h01 && samp_r <= mid)
						votes_r <= vote_cnt;
				end
				if (bit_done) begin
					votes_r   <= 2'h0;
					bit_idx_r <= bit_idx_r + 4'h1;
					// first stop bit ends frame; a second one is never waited for
					if (bit_idx_r == last_bit)
						state_r <= ST_IDLE;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// data and parity capture
	always @(posedge sys_clk) begin
		if (rst || !receiver_enable_r) begin
			shift_r   <= 9'h000;
			par_bit_r <= 1'b0;
		end else if (bit_done) begin
			if (bit_idx_r < data_bits)
				shift_r[bit_idx_r] <= bit_val;
			else if (bit_idx_r != last_bit)
				par_bit_r <= bit_val;
		end
	end

	// hold stage: one finished frame waiting for fifo room
	always @(posedge sys_clk) begin
		if (rst || !receiver_enable_r) begin
			hold_full_r <= 1'b0;
			hold_data_r <= 9'h000;
			hold_fe_r   <= 1'b0;
			hold_pe_r   <= 1'b0;
		end else if (hold_load) begin
			hold_full_r <= 1'b1;
			hold_data_r <= shift_r & data_mask;
			hold_fe_r   <= ~bit_val;
			hold_pe_r   <= par_on && (par_calc != par_bit_r);
		end else if (push) begin
			hold_full_r <= 1'b0;
		end
	end

	// a frame that finds both stages full is dropped
	always @(posedge sys_clk) begin
		if (rst || !receiver_enable_r)
			ovr_pend_r <= 1'b0;
		else if (start_seen && hold_full_r && fifo_full && !pop)
			ovr_pend_r <= 1'b1;
		else if (push)
			ovr_pend_r <= 1'b0;
	end

	// receive fifo
	always @(posedge sys_clk) begin
		if (push)
			fifo_mem[wr_ptr_r] <= {hold_data_r, hold_fe_r, ovr_pend_r, hold_pe_r};
	end

	always @(posedge sys_clk) begin
		if (rst || !receiver_enable_r)
			wr_ptr_r <= 1'b0;
		else if (push)
			wr_ptr_r <= ~wr_ptr_r;
	end

	always @(posedge sys_clk) begin
		if (rst || !receiver_enable_r)
			rd_ptr_r <= 1'b0;
		else if (pop)
			rd_ptr_r <= ~rd_ptr_r;
	end

	always @(posedge sys_clk) begin
		if (rst || !receiver_enable_r)
			count_r <= 2'd0;
		else
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
	end

	// head entry: data[8:0], frame, overrun, parity
	wire [11:0] head = fifo_mem[rd_ptr_r];
	wire        head_pe = head[0] & parity_mode_field_r[1];

	// control and status writes; error positions have no storage
	wire wr_status = reg_wr && (reg_addr == `SRU_ADDR_STATUS_A);
	wire wr_ctrl_b = reg_wr && (reg_addr == `SRU_ADDR_CTRL_B);
	wire wr_ctrl_c = reg_wr && (reg_addr == `SRU_ADDR_CTRL_C);

	always @(posedge sys_clk) begin
		if (rst)
			double_speed_select_r <= 1'b0;
		else if (wr_status)
			double_speed_select_r <= reg_wdata[`SRU_A_DOUBLE];
	end

	always @(posedge sys_clk) begin
		if (rst)
			rx_complete_irq_enable_r <= 1'b0;
		else if (wr_ctrl_b)
			rx_complete_irq_enable_r <= reg_wdata[`SRU_B_IRQ_EN];
	end

	// clearing it stops reception at once
	always @(posedge sys_clk) begin
		if (rst)
			receiver_enable_r <= 1'b0;
		else if (wr_ctrl_b)
			receiver_enable_r <= reg_wdata[`SRU_B_RX_EN];
	end

	always @(posedge sys_clk) begin
		if (rst)
			size2_r <= 1'b0;
		else if (wr_ctrl_b)
			size2_r <= reg_wdata[`SRU_B_SIZE2];
	end

	always @(posedge sys_clk) begin
		if (rst)
			sync_mode_r <= 1'b0;
		else if (wr_ctrl_c)
			sync_mode_r <= reg_wdata[`SRU_C_SYNC];
	end

	always @(posedge sys_clk) begin
		if (rst)
			parity_mode_field_r <= 2'h0;
		else if (wr_ctrl_c)
			parity_mode_field_r <= reg_wdata[`SRU_C_PAR_HI:`SRU_C_PAR_LO];
	end

	always @(posedge sys_clk) begin
		if (rst)
			stop_bit_select_r <= 1'b0;
		else if (wr_ctrl_c)
			stop_bit_select_r <= reg_wdata[`SRU_C_STOP_SEL];
	end

	always @(posedge sys_clk) begin
		if (rst)
			size_lo_r <= `SRU_SIZE_LO_RST;
		else if (wr_ctrl_c)
			size_lo_r <= reg_wdata[`SRU_C_SIZE_HI:`SRU_C_SIZE_LO];
	end

	// read data, one cycle after the strobe
	reg [7:0] rd_val;
	always @* begin
		rd_val = 8'h00;
		case (reg_addr)
		`SRU_ADDR_DATA:     rd_val = rx_complete_flag ? head[10:3] : 8'h00;
		`SRU_ADDR_STATUS_A: begin
			rd_val[`SRU_A_COMPLETE] = rx_complete_flag;
			rd_val[`SRU_A_FRAME_ERR]  = rx_complete_flag & head[2];
			rd_val[`SRU_A_OVERRUN]    = rx_complete_flag & head[1];
			rd_val[`SRU_A_PARITY_ERR] = rx_complete_flag & head_pe;
			rd_val[`SRU_A_DOUBLE]     = double_speed_select_r;
		end
		`SRU_ADDR_CTRL_B: begin
			rd_val[`SRU_B_IRQ_EN] = rx_complete_irq_enable_r;
			rd_val[`SRU_B_RX_EN]  = receiver_enable_r;
			rd_val[`SRU_B_SIZE2]  = size2_r;
			rd_val[`SRU_B_NINTH]  = rx_complete_flag & head[11];
		end
		`SRU_ADDR_CTRL_C: begin
			rd_val[`SRU_C_SYNC]     = sync_mode_r;
			rd_val[`SRU_C_PAR_HI]   = parity_mode_field_r[1];
			rd_val[`SRU_C_PAR_LO]   = parity_mode_field_r[0];
			rd_val[`SRU_C_STOP_SEL] = stop_bit_select_r;
			rd_val[`SRU_C_SIZE_HI]  = size_lo_r[1];
			rd_val[`SRU_C_SIZE_LO]  = size_lo_r[0];
		end
		default: rd_val = 8'h00;
		endcase
	end

	always @(posedge sys_clk) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_val;
		else
			reg_rdata <= 8'h00;
	end

	// pin taken over only while enabled
	assign serial_in_override = receiver_enable_r;
	assign rx_complete_irq    = rx_complete_irq_enable_r & rx_complete_flag;
endmodule
`default_nettype wire

// File: sru_receiver_props.sv
`default_nettype none
module sru_receiver_props (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       serial_in_override,
	input wire logic       rx_complete_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] b_r;
	logic [7:0] c_r;
	logic [2:0] sz;
	assign sz = {b_r[2], c_r[2:1]};
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			b_r <= 8'h00;
			c_r <= 8'h06;
		end else if (reg_wr) begin
			if (reg_addr == 2'h2) b_r <= reg_wdata;
			if (reg_addr == 2'h3) c_r <= reg_wdata;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	pin_take_a: assert property (reg_wr && reg_addr == 2'h2 |=> serial_in_override == $past(reg_wdata[4]))
		else $error("pin takeover does not follow enable");
	flush_off_a: assert property (!serial_in_override |-> !rx_complete_irq)
		else $error("request while receiver off");
	irq_flag_a: assert property (reg_rd && reg_addr == 2'h1 && b_r[7] |=> reg_rdata[7] == $past(rx_complete_irq))
		else $error("complete flag and request disagree");
	short_mask_a: assert property (reg_rd && reg_addr == 2'h0 && sz < 3'h3 |=> (reg_rdata >> ($past(sz) + 5)) == 8'h00)
		else $error("upper data bits not zero");
	par_off_a: assert property (reg_rd && reg_addr == 2'h1 && !c_r[5] |=> !reg_rdata[2])
		else $error("parity error with checking off");
	irq_gate_a: assert property (!b_r[7] |-> !rx_complete_irq)
		else $error("request without enable");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	pop_empty_a: assert property (reg_rd && reg_addr == 2'h0 && !rx_complete_irq && b_r[7] |=> reg_rdata == 8'h00)
		else $error("empty read returned data");
endmodule
bind sru_receiver sru_receiver_props u_props (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.serial_in_override, .rx_complete_irq);
`default_nettype wire

// File: sru_tb.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [1:0] reg_addr = 2'h0, pm;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, got, cc;
	logic [2:0] sz;
	logic       line, xck, ovr, irq, u2x, sync, ie;
	int         err_total = 0, samples_checked = 0, k, nb;
	int         q[$];
	int         tbl[5] = '{0, 1, 2, 3, 7};
	always #25 sys_clk = ~sys_clk;
	sru_line_model LM (.line(line), .xck(xck));
	sru_receiver DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.baud_div(12'h000), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(line),
		.transfer_clock_pin(xck), .serial_in_override(ovr), .rx_complete_irq(irq));
	task chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] g);
		@(posedge sys_clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 g = reg_rdata;
	endtask
	task cfg();
		nb = (sz == 3'h7) ? 9 : sz + 5;
		cc = {1'b0, sync, pm, 1'b0, sz[1:0], 1'b0};
		wr(2'h1, {6'h00, u2x, 1'b0});
		wr(2'h3, cc);
		wr(2'h2, {ie, 2'b00, 1'b1, 1'b0, sz[2], 2'b00});
	endtask
	task automatic frame(input int d, input bit fe, input bit bad);
		logic [12:0] f;
		d = d & ((1 << nb) - 1);
		f = 13'(d) << 1;
		if (pm[1]) f[nb + 1] = ^d ^ pm[0] ^ bad;
		f[nb + 1 + pm[1]] = !fe;
		LM.send(f, nb + 2 + pm[1], u2x ? 400 : 800, sync);
		q.push_back(d | (int'(fe) << 12) | (int'(pm[1] & bad) << 13));
		repeat (40) @(posedge sys_clk);
		#1;
	endtask
	task automatic get();
		int e;
		logic [7:0] m;
		e = q.pop_front();
		m = (sz == 3'h7) ? 8'hff : 8'hfd;
		rd(2'h1, got); chk(got, {1'b1, 2'b00, e[12], e[14], e[13], u2x, 1'b0});
		rd(2'h2, got); chk(got & m, {ie, 2'b00, 1'b1, 1'b0, sz[2], e[8], 1'b0} & m);
		rd(2'h0, got); chk(got, e[7:0]);
	endtask
	task end_of_test();
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#3_000_000 err_total++;
		end_of_test();
	end
	initial begin
		k = $urandom(32'h5397);
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(2'h1, got); chk(got, 8'h00);
		rd(2'h2, got); chk(got, 8'h00);
		rd(2'h3, got); chk(got, 8'h06);
		rd(2'h0, got); chk(got, 8'h00);
		$display("reset test done");
		for (k = 0; k < 10; k++) begin
			sz = tbl[k % 5]; pm = (k % 3 == 0) ? 2'h0 : {1'b1, 1'($urandom)}; sync = $urandom;
			u2x = sync ? 1'b0 : 1'($urandom); ie = 1'b0;
			cfg();
			rd(2'h3, got); chk(got, cc);
			frame($urandom, $urandom % 4 == 0, $urandom % 3 == 0);
			get();
			rd(2'h1, got); chk(got, {6'h00, u2x, 1'b0});
		end
		$display("format test done");
		sz = 3'h3; pm = 2'h0; sync = 1'b0; u2x = 1'b0;
		cfg();
		repeat (4) frame($urandom, 1'b0, 1'b0);
		k = q.pop_back();
		q[2] = q[2] | (1 << 14);
		repeat (3) get();
		rd(2'h1, got); chk(got, 8'h00);
		$display("overrun test done");
		ie = 1'b1;
		cfg();
		frame($urandom, 1'b0, 1'b0);
		chk({7'h00, irq}, 8'h01);
		fork
			frame($urandom, 1'b0, 1'b0);
			begin repeat (120) @(posedge sys_clk); wr(2'h2, 8'h80); end
		join
		q.delete();
		chk({6'h00, ovr, irq}, 8'h00);
		wr(2'h1, 8'h9c);
		rd(2'h1, got); chk(got, 8'h00);
		cfg();
		LM.glitch(150);
		repeat (40) @(posedge sys_clk);
		rd(2'h1, got); chk(got, 8'h00);
		frame($urandom, 1'b0, 1'b0);
		get();
		chk({7'h00, irq}, 8'h00);
		$display("control test done");
		end_of_test();
	end
endmodule
`default_nettype wire
